// ===== hw/cmd_defines.vh
/*
 * Constants of the command interpreter: frame codes, status codes,
 * register offsets, field positions and reset values.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef CMD_DEFINES_VH
`define CMD_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Instruction codes
`define INSTR_RESTORE 8'h0C
`define INSTR_HOME 8'h0D
`define INSTR_SET_OUT 8'h0E
`define INSTR_GET_PORT 8'h0F

// Banks
`define BANK_DIGIN 8'h00
`define BANK_ANALOG 8'h01
`define BANK_OUTPUTS 8'h02
`define BANK_USERVAR 8'h02

// Home search sub-commands and motor range
`define HOME_START 8'h00
`define HOME_STOP 8'h01
`define HOME_STATUS 8'h02
`define HOME_MOTOR_MAX 8'h05

// Special ports and values
`define PORT_ALL 8'hFF
`define PORT_AIN_A 8'h00
`define PORT_AIN_B 8'h04
`define PORT_LINES 8'h08
`define VALUE_FROM_ACCUM 32'hFFFFFFFF
`define VALUE_BYTE_MAX 32'h000000FF
`define VALUE_BIT_MAX 32'h00000001

// Reply status codes
`define ST_OK 8'h64
`define ST_BAD_CHECKSUM 8'h01
`define ST_BAD_INSTR 8'h02
`define ST_BAD_TYPE 8'h03
`define ST_BAD_VALUE 8'h04

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_CMD_HEAD 8'h00
`define OFS_CMD_VALUE 8'h04
`define OFS_CMD_CHK 8'h08
`define OFS_CTRL 8'h0C
`define OFS_REP_HEAD 8'h10
`define OFS_REP_VALUE 8'h14
`define OFS_REP_CHK 8'h18
`define OFS_ACCUM 8'h1C
`define OFS_OUTPUTS 8'h20
`define OFS_STATUS 8'h24

// Field positions
`define CTRL_STANDALONE_BIT 0
`define CTRL_MODULE_LSB 8
`define CTRL_HOST_LSB 16
`define STAT_BUSY_BIT 0
`define STAT_REPLY_BIT 1
`define STAT_DROP_BIT 2
`define STAT_HOME_LSB 8

// Reset values
`define RST_MODULE_ADDR 8'h01
`define RST_HOST_ADDR 8'h02
`define RST_OUTPUTS 8'h00
`define RST_ACCUM 32'h00000000

`endif

// ===== hw/byte_sum8.v
/*
 * Modulo-256 sum of eight bytes, used for frame checksums.
 * Assumes a purely combinational use; no clock.
 */
`timescale 1ns/100ps
`default_nettype none

module byte_sum8 (
	input wire [63:0] bytes_in,
	output reg [7:0] sum_out
);
	integer i; // Byte index

	////////////////////////////////////////////////////////////////////////////
	// Carry out of bit 7 is dropped on purpose: modulo 256
	always @* begin
		sum_out = 8'h00;
		for (i = 0; i < 8; i = i + 1) begin
			sum_out = sum_out + bytes_in[i*8 +: 8];
		end
	end
endmodule

`default_nettype wire

// ===== hw/cmd_interpreter.v
/* Command interpreter: a frame is loaded over AHB-Lite, checked and executed
   (user variable restore, home search, outputs, port reads); the reply is read back.
   Assumes a single-slave AHB-Lite bus on REF_CLK, synchronous inputs,
   and an outside store that acknowledges restore requests. */
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cmd_defines.vh"
// Overview of operation
// - Code 12 bank 2 restores selected user variable
// - Code 13: type 0/1/2 start/stop/status, motor 0-5
// - Home start or stop replies 100, value meaningless
// - Status query: zero idle, nonzero while searching
// - Code 14 bank 2 drives selected output line
// - Ports 0 to 7 map to eight lines
// - Port 255 sets all eight from value bits
// - Value minus one takes setting from accumulator
// - Code 15 reads selected port, banks 0/1/2
// - Digital reads 0/1, analog reads 12 bits
// - Standalone mode copies read value into accumulator
// - Direct mode: reply only, accumulator untouched
// - Port read replies 100 with port state
// - Driven output lines readable through port read
// - Bank 2 read returns previously set outputs
// - Port 255 bank 0 reads all inputs
module cmd_interpreter (
	input wire REF_CLK,
	input wire SRST,
	input wire HSEL,
	input wire [7:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output wire [31:0] HRDATA,
	output wire HREADYOUT,
	output wire HRESP,
	input wire [7:0] GP_IN,
	input wire [11:0] AIN_A,
	input wire [11:0] AIN_B,
	input wire [5:0] HOME_ACTIVE,
	output wire [5:0] HOME_START,
	output wire [5:0] HOME_STOP,
	output wire [7:0] GP_OUT,
	output wire RESTORE_REQ,
	output wire [7:0] RESTORE_INDEX,
	input wire RESTORE_ACK
);
	localparam S_IDLE = 2'h0; // Waiting for a frame
	localparam S_EXEC = 2'h1; // Checking and executing
	localparam S_RESTORE = 2'h2; // Waiting for the store
	////////////////////////////////////////////////////////////////////////////
	// State
	reg [1:0] state_reg; // Frame sequencer
	reg [31:0] cmd_head_reg; // Target, instruction, type, bank
	reg [31:0] cmd_value_reg; // Value, most significant byte first
	reg [7:0] cmd_chk_reg; // Received checksum
	reg standalone_reg; // High: results also go to accumulator
	reg [7:0] module_addr_reg; // Own frame address
	reg [7:0] host_addr_reg; // Address put into replies
	reg [7:0] rep_instr_reg; // Echoed instruction
	reg [7:0] rep_status_reg; // Reply status
	reg [31:0] rep_value_reg; // Reply value
	reg reply_valid_reg; // Reply frame ready
	reg dropped_reg; // Last frame was for another address
	reg [31:0] accum_reg; // Accumulator
	reg [7:0] gp_out_reg; // Bit 0 is gp_output_line_first, bit 7 gp_output_line_last
	reg [5:0] home_start_reg; // One-cycle start pulses
	reg [5:0] home_stop_reg; // One-cycle stop pulses
	reg restore_req_reg; // Held until the store acknowledges
	reg [7:0] restore_index_reg; // User variable to restore
	reg wr_pend_reg; // Write data phase pending
	reg [7:0] wr_addr_reg; // Address of that write
	reg rd_pend_reg; // Read wait state
	reg [7:0] rd_addr_reg; // Address of that read
	reg [31:0] hrdata_reg; // Read data
	reg hready_reg; // Ready toward the bus
	reg hresp_reg; // Always OKAY
	// Frame fields
	wire [7:0] f_target = cmd_head_reg[31:24];
	wire [7:0] f_instr = cmd_head_reg[23:16];
	wire [7:0] f_type = cmd_head_reg[15:8];
	wire [7:0] f_bank = cmd_head_reg[7:0];
	////////////////////////////////////////////////////////////////////////////
	// Checksums
	wire [7:0] cmd_sum; // Sum over the first eight command bytes
	wire [7:0] rep_sum; // Sum over the first eight reply bytes
	byte_sum8 u_cmd_sum (
		.bytes_in({cmd_head_reg, cmd_value_reg}),
		.sum_out(cmd_sum)
	);
	byte_sum8 u_rep_sum (
		.bytes_in({host_addr_reg, module_addr_reg, rep_status_reg, rep_instr_reg,
			rep_value_reg}),
		.sum_out(rep_sum)
	);
	////////////////////////////////////////////////////////////////////////////
	// Port number names one of the eight single lines
	function port_is_line;
		input [7:0] p;
		port_is_line = (p < `PORT_LINES);
	endfunction
	// Single line of an eight-bit group, as 0 or 1
	function [31:0] line_value;
		input [7:0] v;
		input [7:0] p;
		line_value = {31'h00000000, v[p[2:0]]};
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire addr_phase = HSEL & HTRANS[1] & HREADY & (HSIZE == 3'h2); // Word only
	wire busy = (state_reg != S_IDLE);
	wire go = wr_pend_reg & (wr_addr_reg == `OFS_CMD_CHK) & ~busy;
	wire cmd_wr_ok = wr_pend_reg & ~busy; // Frame held stable while busy
	wire acc_bus_wr = wr_pend_reg & (wr_addr_reg == `OFS_ACCUM);
	////////////////////////////////////////////////////////////////////////////
	// Execution decode
	reg [7:0] ex_status; // Status of this frame
	reg [31:0] ex_value; // Value of this frame
	reg ex_restore; // Frame needs the store
	reg ex_out_load; // Outputs change
	reg [7:0] ex_out_val; // New outputs
	reg ex_read; // Frame is a valid port read
	reg [5:0] ex_start; // Start pulses
	reg [5:0] ex_stop; // Stop pulses
	reg [31:0] set_src; // Output setting source
	always @* begin
		ex_status = `ST_OK;
		ex_value = 32'h00000000;
		ex_restore = 1'b0;
		ex_out_load = 1'b0;
		ex_out_val = gp_out_reg;
		ex_read = 1'b0;
		ex_start = 6'h00;
		ex_stop = 6'h00;
		set_src = (cmd_value_reg == `VALUE_FROM_ACCUM) ? accum_reg : cmd_value_reg;
		case (f_instr)
			`INSTR_RESTORE: begin
				// Only the user variable bank can be restored
				ex_restore = (f_bank == `BANK_USERVAR);
				ex_status = ex_restore ? `ST_OK : `ST_BAD_VALUE;
			end
			`INSTR_HOME: begin
				if (f_bank > `HOME_MOTOR_MAX) begin
					ex_status = `ST_BAD_VALUE;
				end else if (f_type == `HOME_START) begin
					ex_start[f_bank[2:0]] = 1'b1;
				end else if (f_type == `HOME_STOP) begin
					ex_stop[f_bank[2:0]] = 1'b1;
				end else if (f_type == `HOME_STATUS) begin
					ex_value = {31'h00000000, HOME_ACTIVE[f_bank[2:0]]};
				end else begin
					ex_status = `ST_BAD_TYPE;
				end
			end
			`INSTR_SET_OUT: begin
				if (f_bank != `BANK_OUTPUTS) begin
					ex_status = `ST_BAD_VALUE;
				end else if (port_is_line(f_type)) begin
					// Accumulator source may be wide; only its bit 0 counts
					if (cmd_value_reg == `VALUE_FROM_ACCUM || cmd_value_reg <= `VALUE_BIT_MAX) begin
						ex_out_load = 1'b1;
						ex_out_val[f_type[2:0]] = set_src[0];
					end else begin
						ex_status = `ST_BAD_VALUE;
					end
				end else if (f_type == `PORT_ALL) begin
					if (cmd_value_reg == `VALUE_FROM_ACCUM || cmd_value_reg <= `VALUE_BYTE_MAX) begin
						ex_out_load = 1'b1;
						ex_out_val = set_src[7:0];
					end else begin
						ex_status = `ST_BAD_VALUE;
					end
				end else begin
					ex_status = `ST_BAD_TYPE;
				end
			end
			`INSTR_GET_PORT: begin
				// Frame value field is not looked at here
				ex_read = 1'b1;
				if (f_bank == `BANK_DIGIN && port_is_line(f_type)) begin
					ex_value = line_value(GP_IN, f_type);
				end else if (f_bank == `BANK_DIGIN && f_type == `PORT_ALL) begin
					ex_value = {24'h000000, GP_IN};
				end else if (f_bank == `BANK_ANALOG && f_type == `PORT_AIN_A) begin
					ex_value = {20'h00000, AIN_A};
				end else if (f_bank == `BANK_ANALOG && f_type == `PORT_AIN_B) begin
					ex_value = {20'h00000, AIN_B};
				end else if (f_bank == `BANK_OUTPUTS && port_is_line(f_type)) begin
					ex_value = line_value(gp_out_reg, f_type);
				end else if (f_bank == `BANK_OUTPUTS && f_type == `PORT_ALL) begin
					ex_value = {24'h000000, gp_out_reg};
				end else begin
					// Unknown bank is a value fault, unknown port a type fault
					ex_read = 1'b0;
					ex_status = (f_bank > `BANK_OUTPUTS) ? `ST_BAD_VALUE : `ST_BAD_TYPE;
				end
			end
			default: begin
				ex_status = `ST_BAD_INSTR;
			end
		endcase
	end
	////////////////////////////////////////////////////////////////////////////
	// Bus front end: writes land in the data phase, reads take one wait
	// state so a read right after a write sees the new value
	always @(posedge REF_CLK) begin
		if (SRST) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= 8'h00;
			hready_reg <= 1'b1;
			hresp_reg <= 1'b0;
		end else begin
			wr_pend_reg <= addr_phase & HWRITE;
			if (addr_phase) begin
				wr_addr_reg <= HADDR;
				rd_addr_reg <= HADDR;
			end
			// Read: drop ready for one cycle
			rd_pend_reg <= addr_phase & ~HWRITE;
			hready_reg <= ~(addr_phase & ~HWRITE);
		end
	end
	// Read data mux; unmapped offsets read zero
	always @(posedge REF_CLK) begin
		if (SRST) begin
			hrdata_reg <= 32'h00000000;
		end else if (rd_pend_reg) begin
			case (rd_addr_reg)
				`OFS_CMD_HEAD: hrdata_reg <= cmd_head_reg;
				`OFS_CMD_VALUE: hrdata_reg <= cmd_value_reg;
				`OFS_CMD_CHK: hrdata_reg <= {24'h000000, cmd_chk_reg};
				`OFS_CTRL: hrdata_reg <= {8'h00, host_addr_reg, module_addr_reg, 7'h00,
					standalone_reg};
				`OFS_REP_HEAD: hrdata_reg <= {host_addr_reg, module_addr_reg, rep_status_reg,
					rep_instr_reg};
				`OFS_REP_VALUE: hrdata_reg <= rep_value_reg;
				`OFS_REP_CHK: hrdata_reg <= {24'h000000, rep_sum};
				`OFS_ACCUM: hrdata_reg <= accum_reg;
				`OFS_OUTPUTS: hrdata_reg <= {24'h000000, gp_out_reg};
				`OFS_STATUS: hrdata_reg <= {18'h00000, HOME_ACTIVE, 5'h00, dropped_reg,
					reply_valid_reg, busy};
				default: hrdata_reg <= 32'h00000000;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Software registers: command frame and configuration
	always @(posedge REF_CLK) begin
		if (SRST) begin
			cmd_head_reg <= 32'h00000000;
			cmd_value_reg <= 32'h00000000;
			cmd_chk_reg <= 8'h00;
			standalone_reg <= 1'b0;
			module_addr_reg <= `RST_MODULE_ADDR;
			host_addr_reg <= `RST_HOST_ADDR;
		end else if (cmd_wr_ok) begin
			case (wr_addr_reg)
				`OFS_CMD_HEAD: cmd_head_reg <= HWDATA;
				`OFS_CMD_VALUE: cmd_value_reg <= HWDATA;
				`OFS_CMD_CHK: cmd_chk_reg <= HWDATA[7:0];
				`OFS_CTRL: begin
					standalone_reg <= HWDATA[`CTRL_STANDALONE_BIT];
					module_addr_reg <= HWDATA[`CTRL_MODULE_LSB +: 8];
					host_addr_reg <= HWDATA[`CTRL_HOST_LSB +: 8];
				end
				default: begin // Other offsets are read only or owned elsewhere
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer, reply, accumulator and outputs
	always @(posedge REF_CLK) begin
		if (SRST) begin
			state_reg <= S_IDLE;
			rep_instr_reg <= 8'h00;
			rep_status_reg <= 8'h00;
			rep_value_reg <= 32'h00000000;
			reply_valid_reg <= 1'b0;
			dropped_reg <= 1'b0;
			accum_reg <= `RST_ACCUM;
			gp_out_reg <= `RST_OUTPUTS;
			home_start_reg <= 6'h00;
			home_stop_reg <= 6'h00;
			restore_req_reg <= 1'b0;
			restore_index_reg <= 8'h00;
		end else begin
			home_start_reg <= 6'h00;
			home_stop_reg <= 6'h00;
			// Software load of the accumulator; a result below overrides it
			if (acc_bus_wr) begin
				accum_reg <= HWDATA;
			end
			case (state_reg)
				S_IDLE: begin
					if (go) begin
						reply_valid_reg <= 1'b0;
						dropped_reg <= 1'b0;
						state_reg <= S_EXEC;
					end
				end
				S_EXEC: begin
					rep_instr_reg <= f_instr;
					if (f_target != module_addr_reg) begin
						// Not for us: no reply at all
						dropped_reg <= 1'b1;
						state_reg <= S_IDLE;
					end else if (cmd_sum != cmd_chk_reg) begin
						rep_status_reg <= `ST_BAD_CHECKSUM;
						rep_value_reg <= 32'h00000000;
						reply_valid_reg <= 1'b1;
						state_reg <= S_IDLE;
					end else if (ex_restore) begin
						restore_req_reg <= 1'b1;
						restore_index_reg <= f_type;
						state_reg <= S_RESTORE;
					end else begin
						rep_status_reg <= ex_status;
						rep_value_reg <= ex_value;
						reply_valid_reg <= 1'b1;
						home_start_reg <= ex_start;
						home_stop_reg <= ex_stop;
						if (ex_out_load) begin
							gp_out_reg <= ex_out_val;
						end
						// Direct mode leaves the accumulator alone
						if (ex_read & standalone_reg) begin
							accum_reg <= ex_value;
						end
						state_reg <= S_IDLE;
					end
				end
				S_RESTORE: begin
					if (RESTORE_ACK) begin
						restore_req_reg <= 1'b0;
						rep_status_reg <= `ST_OK;
						rep_value_reg <= 32'h00000000;
						reply_valid_reg <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	assign HRDATA = hrdata_reg;
	assign HREADYOUT = hready_reg;
	assign HRESP = hresp_reg;
	assign HOME_START = home_start_reg;
	assign HOME_STOP = home_stop_reg;
	assign GP_OUT = gp_out_reg;
	assign RESTORE_REQ = restore_req_reg;
	assign RESTORE_INDEX = restore_index_reg;
endmodule
`default_nettype wire

// ===== dv/search_store_model.sv
/* Partner model: the outside home search engine and user variable store.
   Assumes the interpreter's pulses and restore handshake on the same clock. */
`timescale 1ns/100ps
`default_nettype none
module search_store_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic [5:0] start,
	input wire logic [5:0] stop,
	input wire logic req,
	input wire logic [7:0] index,
	input wire logic [3:0] dly,
	output logic [5:0] active,
	output logic ack,
	output logic [7:0] last_index
);
	logic [3:0] cnt; // Cycles waited on the current restore
	////////////////////////////////////////////////////////////////////////////////
	// Search levels follow pulses; ack comes late so the request must be held
	always @(posedge clk) begin
		if (srst) begin
			active <= 6'h00;
			ack <= 1'b0;
			cnt <= 4'h0;
			last_index <= 8'h00;
		end else begin
			active <= (active | start) & ~stop;
			if (req && !ack) begin
				if (cnt == dly) begin
					ack <= 1'b1;
					last_index <= index;
					cnt <= 4'h0;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end else if (!req) begin
				// Ack is a level held until the request drops
				ack <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/cmd_checker.sv
/* Checker: bus answer timing and output causes of the interpreter.
   Assumes binding to cmd_interpreter with HREADY tied to HREADYOUT. */
`timescale 1ns/100ps
`default_nettype none
module cmd_checker (
	input wire REF_CLK,
	input wire SRST,
	input wire HSEL,
	input wire [7:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire HREADY,
	input wire HREADYOUT,
	input wire HRESP,
	input wire [5:0] HOME_START,
	input wire [5:0] HOME_STOP,
	input wire [7:0] GP_OUT,
	input wire RESTORE_REQ,
	input wire [7:0] RESTORE_INDEX,
	input wire RESTORE_ACK
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	// Accepted word address phase, and the write that starts a frame
	wire taken = HSEL & HTRANS[1] & HREADY & (HSIZE == 3'h2);
	wire go = taken & HWRITE & (HADDR == 8'h08);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_rd;
		taken & !HWRITE;
	endsequence
	sequence s_wait;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	property p_rd_wait;
		s_rd |=> s_wait;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_one_wait;
		!HREADYOUT |=> HREADYOUT;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait too long");
	property p_okay;
		HRESP == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_pulse;
		|HOME_START |=> HOME_START == 6'h00;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	property p_hot;
		$onehot0(HOME_START) && $onehot0(HOME_STOP) && !(|HOME_START && |HOME_STOP);
	endproperty
	a_hot: assert property (p_hot) else $error("pulse not one motor");
	property p_pulse_go;
		(|HOME_START || |HOME_STOP) |-> $past(go, 3);
	endproperty
	a_pulse_go: assert property (p_pulse_go) else $error("pulse without frame");
	property p_out_go;
		GP_OUT != $past(GP_OUT) |-> $past(go, 3);
	endproperty
	a_out_go: assert property (p_out_go) else $error("outputs moved alone");
	property p_req_go;
		$rose(RESTORE_REQ) |-> $past(go, 3);
	endproperty
	a_req_go: assert property (p_req_go) else $error("restore without frame");
	property p_req_hold;
		RESTORE_REQ && !RESTORE_ACK |=> RESTORE_REQ && $stable(RESTORE_INDEX);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("restore dropped");
endmodule
bind cmd_interpreter cmd_checker i_cmd_checker (.REF_CLK(REF_CLK), .SRST(SRST), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .HOME_START(HOME_START), .HOME_STOP(HOME_STOP),
	.GP_OUT(GP_OUT), .RESTORE_REQ(RESTORE_REQ), .RESTORE_INDEX(RESTORE_INDEX),
	.RESTORE_ACK(RESTORE_ACK));
`default_nettype wire

// ===== dv/tb_top.sv
/* Testbench: frames over AHB-Lite, replies compared with expected values worked out in the test.
   Assumes the interpreter as the one slave and the partner model beside it. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic REF_CLK = 0, SRST = 1, HSEL = 0, HWRITE = 0;
	logic [7:0] HADDR = 0, GP_IN = 0;
	logic [1:0] HTRANS = 0;
	logic [2:0] HSIZE = 3'h2; // Word transfers only
	logic [31:0] HWDATA = 0, rd, rv, v;
	logic [11:0] AIN_A = 0, AIN_B = 0;
	logic [3:0] dly = 0; // Partner's restore latency
	wire [31:0] HRDATA;
	wire HREADYOUT, HRESP, RESTORE_REQ, RESTORE_ACK;
	wire [5:0] HOME_ACTIVE, HOME_START, HOME_STOP;
	wire [7:0] GP_OUT, RESTORE_INDEX, idx;
	int err_total = 0, n_tests = 0, i, m, out_m = 0;
	always #2 REF_CLK = ~REF_CLK;
	cmd_interpreter i_cmd_interpreter (.REF_CLK(REF_CLK), .SRST(SRST), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.GP_IN(GP_IN), .AIN_A(AIN_A), .AIN_B(AIN_B), .HOME_ACTIVE(HOME_ACTIVE),
		.HOME_START(HOME_START), .HOME_STOP(HOME_STOP), .GP_OUT(GP_OUT),
		.RESTORE_REQ(RESTORE_REQ), .RESTORE_INDEX(RESTORE_INDEX), .RESTORE_ACK(RESTORE_ACK));
	search_store_model i_search_store_model (.clk(REF_CLK), .srst(SRST), .start(HOME_START),
		.stop(HOME_STOP), .req(RESTORE_REQ), .index(RESTORE_INDEX), .dly(dly),
		.active(HOME_ACTIVE), .ack(RESTORE_ACK), .last_index(idx));
	////////////////////////////////////////////////////////////////////////////////
	// Compare, verdict and bus cycles
	task chk(input string name, input [31:0] seen, input [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task stop_test;
		if (err_total == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// One single transfer; held until hready is sampled high
	task bus(input [7:0] a, input w, input [31:0] d);
		HADDR <= a;
		HTRANS <= 2'h2;
		HWRITE <= w;
		do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask
	function [7:0] s4(input [31:0] w);
		return w[31:24] + w[23:16] + w[15:8] + w[7:0];
	endfunction
	// Load a frame, wait for the reply, check its head and checksum
	task frame(input [7:0] ins, typ, bk, input [31:0] val, input [7:0] tg, input bad,
		input [7:0] st, input [31:0] ev, input cv);
		int n;
		v = {tg, ins, typ, bk};
		bus(8'h00, 1, v);
		bus(8'h04, 1, val);
		bus(8'h08, 1, {24'h0, s4(v) + s4(val) + {7'h0, bad}});
		n = 0;
		do begin bus(8'h24, 0, 0); n++; end while (rd[2:1] == 2'b00 && n < 50);
		chk("reply_wait", rd[2:1] != 2'b00, 1);
		if (tg != 8'h01) begin
			chk("dropped", rd[2:1], 2'b10);
			return;
		end
		bus(8'h10, 0, 0);
		chk("rep_head", rd, {8'h02, 8'h01, st, ins});
		v = rd;
		bus(8'h14, 0, 0);
		rv = rd;
		if (cv) chk("rep_value", rv, ev);
		bus(8'h18, 0, 0);
		chk("rep_chk", rd, {24'h0, s4(v) + s4(rv)});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'h63109fe9));
		repeat (20) @(posedge REF_CLK);
		SRST <= 0;
		HSEL <= 1;
		@(posedge REF_CLK);
		bus(8'h0C, 0, 0);
		chk("ctrl", rd, 32'h00020100);
		bus(8'h30, 0, 0);
		chk("unmapped", rd, 0);
		for (i = 0; i < 8; i++) begin
			m = $urandom % 2;
			frame(8'h0E, i[7:0], 8'h02, m, 8'h01, 0, 8'h64, 0, 0);
			out_m[i] = m[0];
			chk("gp_out", GP_OUT, out_m[7:0]);
		end
		out_m = $urandom % 256;
		frame(8'h0E, 8'hFF, 8'h02, out_m, 8'h01, 0, 8'h64, 0, 0);
		chk("gp_all", GP_OUT, out_m[7:0]);
		GP_IN <= 8'($urandom);
		AIN_A <= 12'($urandom);
		AIN_B <= 12'($urandom);
		// Read back outputs, then inputs, in direct mode
		for (i = 0; i < 18; i++) begin
			m = (i % 9 == 8) ? 255 : i % 9;
			v = (i < 9) ? out_m : GP_IN;
			frame(8'h0F, m[7:0], (i < 9) ? 8'h02 : 8'h00, $urandom, 8'h01, 0, 8'h64,
				(m == 255) ? v : (v >> m) & 1, 1);
		end
		frame(8'h0F, 8'h00, 8'h01, 0, 8'h01, 0, 8'h64, AIN_A, 1);
		frame(8'h0F, 8'h04, 8'h01, 0, 8'h01, 0, 8'h64, AIN_B, 1);
		bus(8'h1C, 0, 0);
		chk("acc_direct", rd, 0);
		// Standalone: read into accumulator, copy to outputs
		bus(8'h0C, 1, 32'h00020101);
		frame(8'h0F, 8'hFF, 8'h00, 0, 8'h01, 0, 8'h64, GP_IN, 1);
		bus(8'h1C, 0, 0);
		chk("acc_sa", rd, GP_IN);
		frame(8'h0E, 8'hFF, 8'h02, 32'hFFFFFFFF, 8'h01, 0, 8'h64, 0, 0);
		out_m = GP_IN;
		chk("gp_acc", GP_OUT, out_m[7:0]);
		frame(8'h0E, 8'h03, 8'h02, 32'hFFFFFFFF, 8'h01, 0, 8'h64, 0, 0);
		out_m[3] = GP_IN[0];
		chk("gp_acc_bit", GP_OUT, out_m[7:0]);
		bus(8'h0C, 1, 32'h00020100);
		// Accumulator loaded by software feeds the outputs in direct mode too
		bus(8'h1C, 1, 32'h0000005A);
		frame(8'h0E, 8'hFF, 8'h02, 32'hFFFFFFFF, 8'h01, 0, 8'h64, 0, 0);
		out_m = 32'h5A;
		chk("gp_acc_bus", GP_OUT, out_m[7:0]);
		frame(8'h0E, 8'h00, 8'h02, 2, 8'h01, 0, 8'h04, 0, 0);
		// Home search per motor: start, status, stop, status
		for (m = 0; m < 6; m++) begin
			frame(8'h0D, 8'h00, m[7:0], 0, 8'h01, 0, 8'h64, 0, 0);
			frame(8'h0D, 8'h02, m[7:0], 0, 8'h01, 0, 8'h64, 0, 0);
			chk("home_on", rv != 0, 1);
			frame(8'h0D, 8'h01, m[7:0], 0, 8'h01, 0, 8'h64, 0, 0);
			frame(8'h0D, 8'h02, m[7:0], 0, 8'h01, 0, 8'h64, 0, 1);
		end
		frame(8'h0D, 8'h00, 8'h06, 0, 8'h01, 0, 8'h04, 0, 0);
		frame(8'h0D, 8'h03, 8'h00, 0, 8'h01, 0, 8'h03, 0, 0);
		dly <= 4'h9;
		frame(8'h0C, 8'h2A, 8'h02, 0, 8'h01, 0, 8'h64, 0, 0);
		chk("restore_idx", idx, 8'h2A);
		// Faults: bad checksum, other target, unknown code
		frame(8'h0E, 8'h00, 8'h02, 1, 8'h01, 1, 8'h01, 0, 1);
		frame(8'h0E, 8'h00, 8'h02, 1, 8'h05, 0, 8'h64, 0, 0);
		frame(8'h20, 8'h00, 8'h00, 0, 8'h01, 0, 8'h02, 0, 0);
		chk("gp_kept", GP_OUT, out_m[7:0]);
		stop_test;
	end
	// Watchdog against a hung handshake
	initial begin
		#100000;
		err_total++;
		stop_test;
	end
endmodule
`default_nettype wire
